//--- design/fpi_image.sv
// What this block does
// R01: Station input image is exactly five bytes long.
// R02: Station byte zero bit zero carries the trigger input, one is active.
// R03: Station bytes one to four carry station temperature, MSB first.
// R04: Each head input image is exactly eight bytes long.
// R05: Head offset zero object temperature, offset four internal temperature, MSB first.
// R06: Each head accepts a three-byte output record.
// R07: Record byte zero is selector, bytes one and two a big-endian value.
// R08: Selectors one to seven write the seven head parameters in order.
// R09: Selector zero discards the value and changes nothing.
// R10: Controller keeps selector zero unless it wants a change.
// R11: Records during data exchange override start-up parameter values.
// R12: Emissivity is times 1000, accepted from 100 to 1100.
// R13: Ambient compensation picks off, numeric background, or external input.
// R14: Relay alarm compares off, target temperature, or head internal temperature.
// R15: Per-head diagnostics enable forwards or suppresses that head's diagnostics.
// R16: Configuration, parameter and external errors become channel diagnostics.
// R17: Each module's data is followed by a validity status byte.
// R18: Head communication loss sets station diagnostic bit two and an interrupt.
// R19: Real values are single-precision floats, sign and exponent byte first.
`timescale 1ns/10ps
`default_nettype none
module fpi_image
  import fpi_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // Station inputs
  input  wire logic                        trig_pin_i,
  input  wire logic [31:0]                 sta_temp_i,
  // Head inputs
  input  wire logic [3:0]                  head_cnt_i,
  input  wire logic [NHEAD-1:0][31:0]      obj_temp_i,
  input  wire logic [NHEAD-1:0][31:0]      int_temp_i,
  input  wire logic [NHEAD-1:0]            comm_ok_i,
  input  wire logic [NHEAD-1:0]            ext_err_i,
  // Configuration
  input  wire logic                        exch_run_i,
  input  wire logic [NHEAD-1:0]            diag_en_i,
  input  wire logic [NHEAD-1:0][1:0]       amb_mode_i,
  input  wire logic [NHEAD-1:0][15:0]      amb_ext_i,
  input  wire logic [NHEAD-1:0][1:0]       rly_mode_i,
  input  wire logic [NHEAD-1:0]            cfg_err_clr_i,
  // Start-up parameter port
  input  wire logic                        init_we_i,
  input  wire logic [2:0]                  init_head_i,
  input  wire logic [7:0]                  init_sel_i,
  input  wire logic [15:0]                 init_val_i,
  // Output record stream
  input  wire logic                        rec_valid_i,
  input  wire logic                        rec_first_i,
  input  wire logic [2:0]                  rec_head_i,
  input  wire logic [7:0]                  rec_data_i,
  output logic                             rec_ready_o,
  // Input image stream
  input  wire logic                        cyc_start_i,
  output logic                             busy_o,
  output logic                             tx_valid_o,
  input  wire logic                        tx_ready_i,
  output logic [7:0]                       tx_data_o,
  output logic [3:0]                       tx_slot_o,
  output logic                             tx_iops_o,
  output logic                             tx_last_o,
  // Parameters
  output logic [NHEAD-1:0][NPRM-1:0][15:0] prm_o,
  output logic [NHEAD-1:0][15:0]           amb_val_o,
  output logic [NHEAD-1:0][31:0]           rly_temp_o,
  output logic [NHEAD-1:0]                 rly_en_o,
  // Diagnostics
  output logic [7:0]                       sta_diag_o,
  output logic                             diag_irq_o,
  output logic [NHEAD-1:0]                 chan_diag_o,
  output logic [NHEAD-1:0]                 cfg_err_o,
  output logic                             rec_drop_o
);

  fpi_state_s       s;
  fpi_state_s       next_s;
  logic             in_ready;
  logic             fire;
  logic [7:0]       in_byte;
  logic             in_iops;
  logic             in_last;
  logic             mod_end;
  logic [3:0]       hcnt;
  logic [NHEAD-1:0] present;
  logic [NHEAD-1:0] head_good;
  logic             ap_en;
  logic [2:0]       ap_head;
  logic [7:0]       ap_sel;
  logic [15:0]      ap_val;
  logic [NHEAD-1:0] err_set;
  logic             lost_now;

  assign hcnt = (head_cnt_i > 4'h8) ? 4'h8 : head_cnt_i;

  always_comb begin
    for (int h = 0; h < NHEAD; h++) begin
      present[h]   = (4'(h) < hcnt);
      head_good[h] = comm_ok_i[h] && !ext_err_i[h];
    end
  end

  assign lost_now = |(present & ~comm_ok_i);

  // Byte generator for the current slot.
  always_comb begin
    in_byte = 8'h00;
    in_iops = 1'b0;
    mod_end = 1'b0;
    if (s.st == ST_STA) begin
      if (s.bidx == 4'h0) begin
        in_byte           = 8'h00;
        in_byte[TRIG_BIT] = s.trig_s2; // R02
      end else if (s.bidx < STA_LEN) begin
        in_byte = fpi_byte_at(s.snap, 4'(s.bidx - 4'h1)); // R03 R19
      end else begin
        in_byte = IOPS_GOOD; // R17
        in_iops = 1'b1;
        mod_end = 1'b1; // R01
      end
    end else if (s.st == ST_HEAD) begin
      if (s.bidx < HEAD_LEN) begin
        in_byte = fpi_byte_at(s.snap, s.bidx); // R05 R19
      end else begin
        in_byte = head_good[s.slot[2:0] - 3'h1] ? IOPS_GOOD : IOPS_BAD; // R17
        in_iops = 1'b1;
        mod_end = 1'b1; // R04
      end
    end
  end

  assign in_last = mod_end && (s.slot >= hcnt);
  assign busy_o  = (s.st != ST_IDLE);
  assign fire    = busy_o && in_ready;

  fpi_buf2 #(
    .W (TX_W)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (busy_o),
    .in_ready_o  (in_ready),
    .in_data_i   ({in_last, in_iops, s.slot, in_byte}),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i),
    .out_data_o  ({tx_last_o, tx_iops_o, tx_slot_o, tx_data_o})
  );

  assign rec_ready_o = 1'b1;

  always_comb begin
    next_s  = s;
    ap_en   = 1'b0;
    ap_head = s.rhead;
    ap_sel  = s.rsel;
    ap_val  = {s.rhi, rec_data_i};
    err_set = '0;

    next_s.trig_s1 = trig_pin_i;
    next_s.trig_s2 = s.trig_s1;

    // Image framing.
    case (s.st)
      ST_IDLE: begin
        if (cyc_start_i) begin
          next_s.st   = ST_STA;
          next_s.slot = 4'h0;
          next_s.bidx = 4'h0;
          next_s.snap = {sta_temp_i, 32'h0000_0000};
        end
      end
      ST_STA, ST_HEAD: begin
        if (fire) begin
          if (!mod_end) begin
            next_s.bidx = 4'(s.bidx + 4'h1);
          end else if (s.slot < hcnt) begin
            next_s.st   = ST_HEAD;
            next_s.slot = 4'(s.slot + 4'h1);
            next_s.bidx = 4'h0;
            next_s.snap = {obj_temp_i[s.slot[2:0]], int_temp_i[s.slot[2:0]]}; // R05
          end else begin
            next_s.st = ST_IDLE;
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase

    // Output record assembly.
    next_s.drop = 1'b0;
    if (rec_valid_i) begin
      if (rec_first_i) begin
        next_s.rcnt  = 2'h1; // R06
        next_s.rsel  = rec_data_i; // R07
        next_s.rhead = rec_head_i;
      end else if (s.rcnt == 2'h1) begin
        next_s.rhi  = rec_data_i; // R07
        next_s.rcnt = 2'h2;
      end else if (s.rcnt == 2'h2) begin
        next_s.rcnt = 2'h0;
        ap_en       = exch_run_i; // R11
      end
    end
    if (!ap_en && init_we_i && !exch_run_i) begin
      ap_en   = 1'b1;
      ap_head = init_head_i;
      ap_sel  = init_sel_i;
      ap_val  = init_val_i;
    end

    if (ap_en) begin
      if (ap_sel == SEL_NONE) begin
        next_s.drop = 1'b1; // R09
      end else if (fpi_prm_ok(ap_sel, ap_val)) begin
        next_s.prm[ap_head][3'(ap_sel - SEL_EMIS)] = ap_val; // R08 R11
      end else begin
        err_set[ap_head] = 1'b1; // R12 R16
      end
    end

    // Errors are sticky; a new error beats a clear in the same cycle.
    next_s.cfg_err = (s.cfg_err & ~cfg_err_clr_i) | err_set; // R16

    for (int h = 0; h < NHEAD; h++) begin
      case (fpi_amb_e'(amb_mode_i[h]))
        AMB_NUM: next_s.amb[h] = s.prm[h][3'(SEL_BKG - SEL_EMIS)]; // R13
        AMB_EXT: next_s.amb[h] = amb_ext_i[h]; // R13
        default: next_s.amb[h] = 16'h0000;
      endcase
      case (fpi_rly_e'(rly_mode_i[h]))
        RLY_TGT: begin
          next_s.rtemp[h] = obj_temp_i[h]; // R14
          next_s.ren[h]   = 1'b1;
        end
        RLY_INT: begin
          next_s.rtemp[h] = int_temp_i[h]; // R14
          next_s.ren[h]   = 1'b1;
        end
        default: begin
          next_s.rtemp[h] = 32'h0000_0000;
          next_s.ren[h]   = 1'b0;
        end
      endcase
      next_s.chan[h] = diag_en_i[h] && present[h] &&
                       (s.cfg_err[h] || ext_err_i[h] || !comm_ok_i[h]); // R15 R16
    end

    next_s.comm_lost = lost_now; // R18
    next_s.irq       = lost_now && !s.comm_lost; // R18
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s     <= '0;
      s.prm <= {NHEAD{PRM_DEF}};
    end else begin
      s <= next_s;
    end
  end

  assign prm_o       = s.prm;
  assign amb_val_o   = s.amb;
  assign rly_temp_o  = s.rtemp;
  assign rly_en_o    = s.ren;
  assign chan_diag_o = s.chan;
  assign cfg_err_o   = s.cfg_err;
  assign rec_drop_o  = s.drop;
  assign diag_irq_o  = s.irq;

  always_comb begin
    sta_diag_o            = 8'h00;
    sta_diag_o[DIAG_COMM] = s.comm_lost; // R18
  end

  chk_trig_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R02
    fire && s.st == ST_STA && s.bidx == 4'h0 |-> in_byte == {7'h00, s.trig_s2})
    else $error("trigger byte wrong");

  chk_sta_len: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R01
    fire && s.st == ST_STA |-> (in_iops == (s.bidx == 4'h5)))
    else $error("station image length wrong");

  chk_head_len: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R04
    fire && s.st == ST_HEAD |-> (in_iops == (s.bidx == 4'h8)))
    else $error("head image length wrong");

  chk_msb_first: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R05
    fire && s.st == ST_HEAD && s.bidx == 4'h4 |-> in_byte == s.snap[31:24])
    else $error("internal temperature not MSB first");

  chk_sta_temp: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R03
    s.st == ST_IDLE && cyc_start_i |=> s.snap[63:32] == $past(sta_temp_i))
    else $error("station temperature not captured");

  chk_zero_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R09
    ap_en && ap_sel == 8'h00 |=> s.prm == $past(s.prm) && rec_drop_o)
    else $error("selector zero changed a parameter");

  chk_rec_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R08
    ap_en && ap_sel >= 8'h02 && ap_sel <= 8'h07
    |=> s.prm[$past(ap_head)][$past(ap_sel) - 8'h01] == $past(ap_val))
    else $error("parameter not written");

  chk_emis_range: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
    ap_en && ap_sel == 8'h01 && (ap_val < 16'h0064 || ap_val > 16'h044c)
    |=> cfg_err_o[$past(ap_head)] && s.prm == $past(s.prm))
    else $error("emissivity range not enforced");

  chk_comm_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R18
    $rose(sta_diag_o[2]) |-> diag_irq_o ##1 !diag_irq_o)
    else $error("communication loss interrupt missing");

  chk_iops_val: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R17
    fire && in_iops && s.st == ST_HEAD |-> (in_byte == 8'h80) == head_good[s.slot[2:0] - 3'h1])
    else $error("status byte does not match head state");

  chk_init_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
    exch_run_i && !rec_valid_i |=> prm_o == $past(prm_o))
    else $error("parameters changed without a record");

  chk_diag_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R15
    1'h1 |=> (chan_diag_o & ~$past(diag_en_i)) == 8'h00)
    else $error("suppressed head diagnostic forwarded");

  chk_err_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R16
    err_set != 8'h00 |=> (cfg_err_o & $past(err_set)) == $past(err_set))
    else $error("parameter error not flagged");

  chk_amb_ext: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
    amb_mode_i[0] == 2'h2 |=> amb_val_o[0] == $past(amb_ext_i[0]))
    else $error("external ambient value not selected");

  cov_full_image: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    fire && in_last && s.slot == 4'h8);

  cov_stall: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    busy_o && !in_ready);

  cov_rec_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    ap_en && exch_run_i && ap_sel == 8'h01);

  cov_rec_drop: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    rec_drop_o);

endmodule
`default_nettype wire

//--- design/fpi_pkg.sv
package fpi_pkg;

  localparam int          NHEAD     = 8;
  localparam int          NPRM      = 7;
  localparam logic [3:0]  STA_LEN   = 4'h5;
  localparam logic [3:0]  HEAD_LEN  = 4'h8;
  localparam logic [1:0]  REC_LEN   = 2'h3;
  localparam int          TRIG_BIT  = 0;
  localparam int          DIAG_COMM = 2;
  localparam logic [7:0]  IOPS_GOOD = 8'h80;
  localparam logic [7:0]  IOPS_BAD  = 8'h00;
  localparam logic [7:0]  SEL_NONE  = 8'h00;
  localparam logic [7:0]  SEL_EMIS  = 8'h01;
  localparam logic [7:0]  SEL_LASER = 8'h02;
  localparam logic [7:0]  SEL_BKG   = 8'h03;
  localparam logic [7:0]  SEL_AVG   = 8'h04;
  localparam logic [7:0]  SEL_PEAK  = 8'h05;
  localparam logic [7:0]  SEL_VALL  = 8'h06;
  localparam logic [7:0]  SEL_SETP  = 8'h07;
  localparam logic [15:0] EMIS_MIN  = 16'h0064;
  localparam logic [15:0] EMIS_MAX  = 16'h044c;
  localparam logic [15:0] EMIS_DEF  = 16'h03e8;
  localparam logic [NPRM-1:0][15:0] PRM_DEF = {16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                              16'h0000, 16'h0000, EMIS_DEF};
  localparam int          TX_W      = 14;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STA  = 2'b01,
    ST_HEAD = 2'b10
  } fpi_st_e;

  typedef enum logic [1:0] {
    AMB_OFF = 2'b00,
    AMB_NUM = 2'b01,
    AMB_EXT = 2'b10
  } fpi_amb_e;

  typedef enum logic [1:0] {
    RLY_OFF = 2'b00,
    RLY_TGT = 2'b01,
    RLY_INT = 2'b10
  } fpi_rly_e;

  typedef struct packed {
    fpi_st_e                        st;
    logic [3:0]                     slot;
    logic [3:0]                     bidx;
    logic [63:0]                    snap;
    logic                           trig_s1;
    logic                           trig_s2;
    logic [1:0]                     rcnt;
    logic [7:0]                     rsel;
    logic [7:0]                     rhi;
    logic [2:0]                     rhead;
    logic [NHEAD-1:0][NPRM-1:0][15:0] prm;
    logic [NHEAD-1:0]               cfg_err;
    logic                           comm_lost;
    logic                           irq;
    logic                           drop;
    logic [NHEAD-1:0][15:0]         amb;
    logic [NHEAD-1:0][31:0]         rtemp;
    logic [NHEAD-1:0]               ren;
    logic [NHEAD-1:0]               chan;
  } fpi_state_s;

  function automatic logic [7:0] fpi_byte_at(input logic [63:0] w, input logic [3:0] i);
    logic [63:0] t;
    t = w << {i[2:0], 3'b000};
    return t[63:56];
  endfunction

  function automatic logic fpi_prm_ok(input logic [7:0] sel, input logic [15:0] val);
    logic ok;
    ok = (sel >= SEL_EMIS) && (sel <= SEL_SETP);
    if (sel == SEL_EMIS) begin
      ok = (val >= EMIS_MIN) && (val <= EMIS_MAX);
    end
    return ok;
  endfunction

endpackage

//--- design/fpi_buf2.sv
`timescale 1ns/10ps
`default_nettype none
module fpi_buf2 #(
  parameter int W = 14
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } fpi_buf_s;

  fpi_buf_s s;
  fpi_buf_s next_s;
  logic     push;
  logic     pop;

  assign in_ready_o  = (s.cnt != 2'h2);
  assign out_valid_o = (s.cnt != 2'h0);
  assign out_data_o  = s.mem[s.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp        = ~s.wp;
    end
    if (pop) begin
      next_s.rp = ~s.rp;
    end
    next_s.cnt = 2'(s.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

//--- verification/fpi_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module fpi_ctrl_model
  import fpi_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Record stream
  output logic            rec_valid_o,
  output logic            rec_first_o,
  output logic [2:0]      rec_head_o,
  output logic [7:0]      rec_data_o,
  // Image stream
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  input  wire logic [7:0] tx_data_i,
  input  wire logic [3:0] tx_slot_i,
  input  wire logic       tx_iops_i,
  input  wire logic       tx_last_i,
  // Stall mode: 0 ready, 1 random, 2 held off
  input  wire logic [1:0] stall_i
);
  logic [13:0] got_q [$];
  integer      seed = 32'h81e2245c;

  initial begin
    rec_valid_o = 1'b0;
    rec_first_o = 1'b0;
    rec_head_o  = 3'h0;
    rec_data_o  = SEL_NONE;
    tx_ready_o  = 1'b0;
  end

  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_q.push_back({tx_last_i, tx_iops_i, tx_slot_i, tx_data_i});
    end
    tx_ready_o <= (stall_i == 2'h0) || ((stall_i == 2'h1) && ($random(seed) % 3 != 0));
  end

  task automatic send_rec(input logic [2:0] h, input logic [7:0] sel, input logic [15:0] v);
    logic [7:0] b [3];
    b = '{sel, v[15:8], v[7:0]};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      rec_valid_o <= 1'b1;
      rec_first_o <= (i == 0);
      rec_head_o  <= h;
      rec_data_o  <= b[i];
    end
    @(posedge clk_i);
    rec_valid_o <= 1'b0;
    rec_first_o <= 1'b0;
    rec_data_o  <= SEL_NONE;
  endtask
endmodule
`default_nettype wire

//--- verification/fpi_image_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module fpi_image_tb_top;
  import fpi_pkg::*;

  logic                        clk_i = 1'b0;
  logic                        rst_n_i = 1'b0;
  logic                        trig_pin_i = 1'b0;
  logic [31:0]                 sta_temp_i = '0;
  logic [3:0]                  head_cnt_i = 4'h8;
  logic [NHEAD-1:0][31:0]      obj_temp_i = '0;
  logic [NHEAD-1:0][31:0]      int_temp_i = '0;
  logic [NHEAD-1:0]            comm_ok_i = '1;
  logic [NHEAD-1:0]            ext_err_i = '0;
  logic                        exch_run_i = 1'b0;
  logic [NHEAD-1:0]            diag_en_i = '1;
  logic [NHEAD-1:0][1:0]       amb_mode_i = '0;
  logic [NHEAD-1:0][15:0]      amb_ext_i = '0;
  logic [NHEAD-1:0][1:0]       rly_mode_i = '0;
  logic [NHEAD-1:0]            cfg_err_clr_i = '0;
  logic                        init_we_i = 1'b0;
  logic [2:0]                  init_head_i = 3'h0;
  logic [7:0]                  init_sel_i = 8'h00;
  logic [15:0]                 init_val_i = 16'h0000;
  logic                        cyc_start_i = 1'b0;
  logic                        rec_valid_i, rec_first_i, rec_ready_o, tx_ready_i;
  logic [2:0]                  rec_head_i;
  logic [7:0]                  rec_data_i, tx_data_o, sta_diag_o, chan_diag_o, cfg_err_o;
  logic                        busy_o, tx_valid_o, tx_iops_o, tx_last_o, diag_irq_o, rec_drop_o;
  logic [3:0]                  tx_slot_o;
  logic [NHEAD-1:0][NPRM-1:0][15:0] prm_o;
  logic [NHEAD-1:0][15:0]      amb_val_o;
  logic [NHEAD-1:0][31:0]      rly_temp_o;
  logic [NHEAD-1:0]            rly_en_o;
  logic [15:0]                 exp_prm [NHEAD][NPRM];
  logic [7:0]                  exp_cfg = '0;
  logic [1:0]                  stall = 2'h0;
  logic [15:0]                 v;
  integer                      seed = 32'h81e2245c;
  int                          n_fail = 0;
  int                          n_compared = 0;
  int                          n_drop = 0;
  int                          n_exp_drop = 0;
  int                          n_irq = 0;
  int                          cyc = 0;

  fpi_image i_dut (.clk_i, .rst_n_i, .trig_pin_i, .sta_temp_i, .head_cnt_i, .obj_temp_i, .int_temp_i,
    .comm_ok_i, .ext_err_i, .exch_run_i, .diag_en_i, .amb_mode_i, .amb_ext_i, .rly_mode_i, .cfg_err_clr_i,
    .init_we_i, .init_head_i, .init_sel_i, .init_val_i, .rec_valid_i, .rec_first_i, .rec_head_i,
    .rec_data_i, .rec_ready_o, .cyc_start_i, .busy_o, .tx_valid_o, .tx_ready_i, .tx_data_o, .tx_slot_o,
    .tx_iops_o, .tx_last_o, .prm_o, .amb_val_o, .rly_temp_o, .rly_en_o, .sta_diag_o, .diag_irq_o,
    .chan_diag_o, .cfg_err_o, .rec_drop_o);

  fpi_ctrl_model i_ctrl (.clk_i(clk_i), .rec_valid_o(rec_valid_i), .rec_first_o(rec_first_i),
    .rec_head_o(rec_head_i), .rec_data_o(rec_data_i), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
    .tx_data_i(tx_data_o), .tx_slot_i(tx_slot_o), .tx_iops_i(tx_iops_o), .tx_last_i(tx_last_o),
    .stall_i(stall));

  always #10 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc++;
    n_drop += (rec_drop_o === 1'b1);
    n_irq += (diag_irq_o === 1'b1);
    if (cyc == 40000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic expect_prm(input logic [2:0] h, input logic [7:0] sel, input logic [15:0] val);
    if (sel == 8'h00) begin
      n_exp_drop++;
    end else if (sel > 8'h07 || (sel == 8'h01 && (val < 16'h0064 || val > 16'h044c))) begin
      exp_cfg[h] = 1'b1;
    end else begin
      exp_prm[h][sel-8'h01] = val;
    end
  endtask

  task automatic check_all();
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    for (int h = 0; h < NHEAD; h++) begin
      for (int p = 0; p < NPRM; p++) begin
        chk("prm", exp_prm[h][p], prm_o[h][p]);
      end
    end
    chk("cfg_err", exp_cfg, cfg_err_o);
    chk("drops", n_exp_drop, n_drop);
  endtask

  task automatic do_rec(input logic [2:0] h, input logic [7:0] sel, input logic [15:0] val);
    i_ctrl.send_rec(h, sel, val);
    if (exch_run_i) expect_prm(h, sel, val);
    check_all();
  endtask

  task automatic do_init(input logic [2:0] h, input logic [7:0] sel, input logic [15:0] val);
    @(posedge clk_i);
    init_we_i   <= 1'b1;
    init_head_i <= h;
    init_sel_i  <= sel;
    init_val_i  <= val;
    @(posedge clk_i);
    init_we_i <= 1'b0;
    if (!exch_run_i) expect_prm(h, sel, val);
    check_all();
  endtask

  task automatic run_image(input logic [3:0] nh, input logic [1:0] md);
    logic [13:0] e [$];
    logic [31:0] w;
    int          n;
    @(posedge clk_i);
    trig_pin_i <= 1'($random(seed));
    sta_temp_i <= $random(seed);
    ext_err_i  <= 8'($random(seed));
    head_cnt_i <= nh;
    for (int h = 0; h < NHEAD; h++) begin
      obj_temp_i[h] <= $random(seed);
      int_temp_i[h] <= $random(seed);
    end
    stall <= 2'h2;
    repeat (4) @(posedge clk_i);
    e = {};
    e.push_back({6'h00, 7'h00, trig_pin_i});
    for (int k = 3; k >= 0; k--) begin
      e.push_back({6'h00, sta_temp_i[8*k+:8]});
    end
    e.push_back({6'h10, IOPS_GOOD});
    for (int h = 0; h < nh; h++) begin
      for (int k = 7; k >= 0; k--) begin
        w = (k > 3) ? obj_temp_i[h] : int_temp_i[h];
        e.push_back({2'b00, 4'(h + 1), w[8*(k%4)+:8]});
      end
      e.push_back({2'b01, 4'(h + 1), (comm_ok_i[h] && !ext_err_i[h]) ? IOPS_GOOD : IOPS_BAD});
    end
    e[e.size()-1][13] = 1'b1;
    cyc_start_i <= 1'b1;
    @(posedge clk_i);
    cyc_start_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk("held valid", 1, tx_valid_o);
    @(posedge clk_i);
    stall <= md;
    n = 0;
    while ((i_ctrl.got_q.size() < e.size() || busy_o !== 1'b0) && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    @(negedge clk_i);
    chk("image length", e.size(), i_ctrl.got_q.size());
    chk("drained", 0, tx_valid_o);
    for (int i = 0; i < e.size() && i < i_ctrl.got_q.size(); i++) begin
      chk("image byte", e[i], i_ctrl.got_q[i]);
    end
    i_ctrl.got_q = {};
  endtask

  initial begin
    for (int h = 0; h < NHEAD; h++) begin
      for (int p = 0; p < NPRM; p++) begin
        exp_prm[h][p] = (p == 0) ? 16'h03e8 : 16'h0000;
      end
    end
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk("rec_ready", 1, rec_ready_o);
    check_all();
    run_image(4'h8, 2'h1);
    run_image(4'h3, 2'h0);
    run_image(4'h0, 2'h1);
    do_init(3'h5, 8'h04, 16'($random(seed)));
    do_rec(3'h5, 8'h04, 16'($random(seed)));
    @(posedge clk_i);
    exch_run_i <= 1'b1;
    do_rec(3'h5, 8'h04, 16'($random(seed)));
    do_init(3'h2, 8'h05, 16'h1234);
    for (int s = 1; s <= 7; s++) begin
      v = (s == 1) ? 16'h0064 + 16'($unsigned($random(seed)) % 1001) : 16'($random(seed));
      do_rec(3'($random(seed)), 8'(s), v);
    end
    for (int i = 0; i < 8; i++) begin
      do_rec(3'h1, 8'h01, (i < 2) ? 16'h0063 + 16'(i) : 16'h044b + 16'(i - 2));
    end
    do_rec(3'h2, 8'h08, 16'h0101);
    do_rec(3'h6, 8'h00, 16'hffff);
    @(posedge clk_i);
    cfg_err_clr_i <= '1;
    ext_err_i     <= '0;
    head_cnt_i    <= 4'h2;
    comm_ok_i[5]  <= 1'b0;
    @(posedge clk_i);
    cfg_err_clr_i <= '0;
    exp_cfg = '0;
    check_all();
    chk("sta_diag", 0, sta_diag_o);
    chk("chan_diag", 8'h00, chan_diag_o);
    @(posedge clk_i);
    head_cnt_i <= 4'h8;
    check_all();
    chk("sta_diag", 32'h1 << DIAG_COMM, sta_diag_o);
    chk("irq", 1, n_irq);
    chk("chan_diag", 8'h20, chan_diag_o);
    @(posedge clk_i);
    diag_en_i[5] <= 1'b0;
    check_all();
    chk("chan_diag", 8'h00, chan_diag_o);
    @(posedge clk_i);
    comm_ok_i <= '1;
    ext_err_i <= 8'h02;
    for (int h = 0; h < NHEAD; h++) begin
      amb_ext_i[h] <= 16'($random(seed));
    end
    check_all();
    chk("chan_diag", 8'h02, chan_diag_o);
    chk("sta_diag", 0, sta_diag_o);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      amb_mode_i <= {NHEAD{2'(m)}};
      rly_mode_i <= {NHEAD{2'(m)}};
      check_all();
      for (int h = 0; h < NHEAD; h++) begin
        chk("amb", (m == 1) ? exp_prm[h][2] : (m == 2) ? amb_ext_i[h] : 16'h0000, amb_val_o[h]);
        chk("rly temp", (m == 1) ? obj_temp_i[h] : (m == 2) ? int_temp_i[h] : 32'h0, rly_temp_o[h]);
        chk("rly en", m == 1 || m == 2, rly_en_o[h]);
      end
    end
    final_report();
  end
endmodule
`default_nettype wire
